// [rtl/fan_cfg_pkg.sv]
// Purpose: shared constants for the fan monitor configuration and status bank
// Assumes: 50 MHz core clock, 8-bit registers on a byte-wide register port
// Notes: times are held in milliseconds and turned into cycle counts here
`default_nettype none

package fan_cfg_pkg;

  // clock rate
  localparam int CLK_HZ = 50_000_000;

  // register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_CFG4 = 8'h04;
  localparam logic [7:0] ADDR_CFG3 = 8'h3f;

  // config three field positions
  localparam int CFG3_FULLSPEED_BIT = 7;
  localparam int CFG3_REV_MSB = 3;
  localparam int CFG3_REV_LSB = 0;

  // config four field positions
  localparam int CFG4_MODE_BIT = 7;
  localparam int CFG4_PPR_BIT = 6;
  localparam int CFG4_FAST_BIT = 5;
  localparam int CFG4_OL_EN_BIT = 4;

  // fixed read-back pattern of config four reserved bits
  localparam logic [7:0] CFG4_FIXED = 8'h08;

  // reset values of the writable bits and the status flags
  localparam logic CFG3_FULLSPEED_RST = 1'b1;
  localparam logic CFG4_MODE_RST = 1'b0;
  localparam logic CFG4_PPR_RST = 1'b0;
  localparam logic CFG4_FAST_RST = 1'b0;
  localparam logic CFG4_OL_EN_RST = 1'b0;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // status bit positions
  localparam int STAT_REMOTE_FAIL_BIT = 5;
  localparam int STAT_REMOTE_CRIT_BIT = 4;

  // flags that a status read never clears
  localparam logic [7:0] STATUS_NO_RD_CLEAR = 8'h20;

  // pulses per revolution choices
  localparam logic [2:0] PPR_TWO = 3'h2;
  localparam logic [2:0] PPR_FOUR = 3'h4;

  // speed reading refresh intervals
  localparam int FAST_UPDATE_MS = 250;
  localparam int SLOW_UPDATE_MS = 1000;
  localparam int FAST_UPDATE_CYCLES = (CLK_HZ / 1000) * FAST_UPDATE_MS;
  localparam int SLOW_UPDATE_CYCLES = (CLK_HZ / 1000) * SLOW_UPDATE_MS;

  // unmapped read answer
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

endpackage : fan_cfg_pkg

`default_nettype wire

// [rtl/speed_update_timer.sv]
// Purpose: one-cycle tick at the speed reading refresh interval
// Assumes: interval select may change at any time
// Notes: a change of select restarts the count so no interval is cut short
`default_nettype none

module speed_update_timer #(
  parameter int FAST_CYCLES = fan_cfg_pkg::FAST_UPDATE_CYCLES,
  parameter int SLOW_CYCLES = fan_cfg_pkg::SLOW_UPDATE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic fast,
  // tick out
  output logic tick
);

  localparam logic [31:0] FAST_LAST = 32'(FAST_CYCLES - 1);
  localparam logic [31:0] SLOW_LAST = 32'(SLOW_CYCLES - 1);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic fast_q;
  logic fast_d;
  logic tick_q;
  logic tick_d;

  // count down the selected interval
  always_comb begin
    fast_d = fast;
    tick_d = 1'b0;
    if (fast != fast_q) begin
      cnt_d = fast ? FAST_LAST : SLOW_LAST;
    end else if (cnt_q == 32'h0) begin
      cnt_d = fast ? FAST_LAST : SLOW_LAST;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q - 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= SLOW_LAST;
      fast_q <= fan_cfg_pkg::CFG4_FAST_RST;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      fast_q <= fast_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // tick lasts a single cycle
  tick_single_a: assert property (tick_q |=> !tick_q)
    else $error("update tick longer than one cycle");

  // reload value follows the selected interval
  reload_sel_a: assert property ((cnt_q == 32'h0 && fast == fast_q) |=>
      (cnt_q == (fast_q ? FAST_LAST : SLOW_LAST)))
    else $error("update interval reload wrong");

endmodule : speed_update_timer

`default_nettype wire

// [rtl/fan_monitor_config_status_regs.sv]
// Purpose: config three, config four and status register bank of the fan monitor
// Assumes: the serial bus front end presents byte accesses as one-cycle strobes
// Notes: read data is captured at the strobe edge and valid one cycle later
//
// Contract
// - enable set: our own overtemp drive forces full fan speed.
// - enable clear: our own overtemp drive does not force full speed.
// - overtemp pin pulled low externally always forces full fan speed; the code sees the pull only while ot_oe_q is clear.
// - config three bits 3:0 are a read-only revision, bit 3 most significant.
// - writes to reserved bits do nothing; they keep their fixed values.
// - pulses per revolution select: zero means two, one means four.
// - fast update bit gives 250 ms refresh, clear gives one second.
// - overlimit enable lets us drive the pin; clear leaves it released.
// - reading the status register clears its flags except stated exceptions.
// - a flag stays set until its condition is gone and it is read.
// - a flag cleared by read sets again next monitor cycle if condition holds.
// - remote sensor failure flag is not a read-to-clear flag.
// - remote sensor failure flag holds until power-on or software reset.
// - remote over critical limit sets its flag and drives overtemp low.
`default_nettype none

module fan_monitor_config_status_regs #(
  parameter int FAST_CYCLES = fan_cfg_pkg::FAST_UPDATE_CYCLES,
  parameter int SLOW_CYCLES = fan_cfg_pkg::SLOW_UPDATE_CYCLES,
  parameter logic [3:0] REVISION = 4'h5 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // monitoring inputs
  input wire logic monitor_tick,
  input wire logic [7:0] limit_cond,
  input wire logic remote_crit_cond,
  input wire logic remote_fail_cond,
  input wire logic overlimit_cond,
  // overtemp open-drain pin, active low
  input wire logic overtemp_pin_i,
  output logic overtemp_pin_o,
  output logic overtemp_pin_oe,
  // overlimit open-drain pin, active low
  output logic overlimit_pin_o,
  output logic overlimit_pin_oe,
  // fan control and speed measurement
  output logic fan_full_speed,
  output logic [2:0] pulses_per_rev,
  output logic fast_speed_update,
  output logic speed_update_tick,
  output logic mode_configured
);

  // configuration state
  logic fullspeed_en_q;
  logic fullspeed_en_d;
  logic mode_q;
  logic mode_d;
  logic ppr_sel_q;
  logic ppr_sel_d;
  logic fast_q;
  logic fast_d;
  logic ol_en_q;
  logic ol_en_d;

  // status and read path state
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // pin and fan state
  logic ot_oe_q;
  logic ot_oe_d;
  logic ol_oe_q;
  logic ol_oe_d;
  logic full_q;
  logic full_d;
  logic [2:0] ppr_q;
  logic [2:0] ppr_d;

  // decoded views
  logic [7:0] cfg3_view;
  logic [7:0] cfg4_view;
  logic [7:0] cond_now;
  logic [7:0] set_mask;
  logic [7:0] clr_mask;
  logic ext_pull;
  logic tick_w;

  // register read-back images
  always_comb begin
    cfg3_view = 8'h00;
    cfg3_view[fan_cfg_pkg::CFG3_FULLSPEED_BIT] = fullspeed_en_q;
    cfg3_view[fan_cfg_pkg::CFG3_REV_MSB:fan_cfg_pkg::CFG3_REV_LSB] = REVISION;
    cfg4_view = fan_cfg_pkg::CFG4_FIXED;
    cfg4_view[fan_cfg_pkg::CFG4_MODE_BIT] = mode_q;
    cfg4_view[fan_cfg_pkg::CFG4_PPR_BIT] = ppr_sel_q;
    cfg4_view[fan_cfg_pkg::CFG4_FAST_BIT] = fast_q;
    cfg4_view[fan_cfg_pkg::CFG4_OL_EN_BIT] = ol_en_q;
  end

  // configuration writes; only writable bits are taken
  always_comb begin
    fullspeed_en_d = fullspeed_en_q;
    mode_d = mode_q;
    ppr_sel_d = ppr_sel_q;
    fast_d = fast_q;
    ol_en_d = ol_en_q;
    if (reg_wr && reg_addr == fan_cfg_pkg::ADDR_CFG3) begin
      fullspeed_en_d = reg_wdata[fan_cfg_pkg::CFG3_FULLSPEED_BIT];
    end
    if (reg_wr && reg_addr == fan_cfg_pkg::ADDR_CFG4) begin
      mode_d = reg_wdata[fan_cfg_pkg::CFG4_MODE_BIT];
      ppr_sel_d = reg_wdata[fan_cfg_pkg::CFG4_PPR_BIT];
      fast_d = reg_wdata[fan_cfg_pkg::CFG4_FAST_BIT];
      ol_en_d = reg_wdata[fan_cfg_pkg::CFG4_OL_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fullspeed_en_q <= fan_cfg_pkg::CFG3_FULLSPEED_RST;
      mode_q <= fan_cfg_pkg::CFG4_MODE_RST;
      ppr_sel_q <= fan_cfg_pkg::CFG4_PPR_RST;
      fast_q <= fan_cfg_pkg::CFG4_FAST_RST;
      ol_en_q <= fan_cfg_pkg::CFG4_OL_EN_RST;
    end else begin
      fullspeed_en_q <= fullspeed_en_d;
      mode_q <= mode_d;
      ppr_sel_q <= ppr_sel_d;
      fast_q <= fast_d;
      ol_en_q <= ol_en_d;
    end
  end

  // present out-of-limit conditions per flag
  always_comb begin
    cond_now = limit_cond;
    cond_now[fan_cfg_pkg::STAT_REMOTE_CRIT_BIT] = remote_crit_cond;
    cond_now[fan_cfg_pkg::STAT_REMOTE_FAIL_BIT] = remote_fail_cond;
  end

  // per-flag set and read-clear terms
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      if (gi == fan_cfg_pkg::STAT_REMOTE_FAIL_BIT) begin : g_fail
        // failure latches at once and ignores reads
        assign set_mask[gi] = remote_fail_cond;
        assign clr_mask[gi] = 1'b0;
      end else begin : g_sticky
        assign set_mask[gi] = monitor_tick & cond_now[gi];
        assign clr_mask[gi] = reg_rd & (reg_addr == fan_cfg_pkg::ADDR_STATUS) &
            ~cond_now[gi];
      end
    end
  endgenerate

  // status next value; set wins over a same-cycle clear
  always_comb begin
    status_d = (status_q & ~clr_mask) | set_mask;
    if (soft_rst) begin
      status_d = fan_cfg_pkg::STATUS_RST;
    end
  end

  // read data captured from the current image at the strobe edge
  always_comb begin
    rvalid_d = reg_rd;
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        fan_cfg_pkg::ADDR_STATUS: begin
          rdata_d = status_q;
        end
        fan_cfg_pkg::ADDR_CFG3: begin
          rdata_d = cfg3_view;
        end
        fan_cfg_pkg::ADDR_CFG4: begin
          rdata_d = cfg4_view;
        end
        default: begin
          rdata_d = fan_cfg_pkg::UNMAPPED_RDATA;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= fan_cfg_pkg::STATUS_RST;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      status_q <= status_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // external pull-low seen only while we release the pin
  assign ext_pull = ~overtemp_pin_i & ~ot_oe_q;

  // pin drive and fan full speed decisions
  always_comb begin
    ot_oe_d = remote_crit_cond;
    ol_oe_d = ol_en_q & (overlimit_cond | status_q[fan_cfg_pkg::STAT_REMOTE_FAIL_BIT]);
    full_d = ext_pull | (ot_oe_q & fullspeed_en_q);
    ppr_d = ppr_sel_q ? fan_cfg_pkg::PPR_FOUR : fan_cfg_pkg::PPR_TWO;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ot_oe_q <= 1'b0;
      ol_oe_q <= 1'b0;
      full_q <= 1'b0;
      ppr_q <= fan_cfg_pkg::PPR_TWO;
    end else begin
      ot_oe_q <= ot_oe_d;
      ol_oe_q <= ol_oe_d;
      full_q <= full_d;
      ppr_q <= ppr_d;
    end
  end

  // refresh interval of the speed reading
  speed_update_timer #(
    .FAST_CYCLES(FAST_CYCLES),
    .SLOW_CYCLES(SLOW_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .fast(fast_q),
    .tick(tick_w)
  );

  // outputs straight from flops, except the two pin data outputs tied low
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign overtemp_pin_o = 1'b0;
  assign overtemp_pin_oe = ot_oe_q;
  assign overlimit_pin_o = 1'b0;
  assign overlimit_pin_oe = ol_oe_q;
  assign fan_full_speed = full_q;
  assign pulses_per_rev = ppr_q;
  assign fast_speed_update = fast_q;
  assign speed_update_tick = tick_w;
  assign mode_configured = mode_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // own drive with enable gives full speed next cycle
  own_drive_full_a: assert property ((ot_oe_q && fullspeed_en_q) |=> full_q)
    else $error("no full speed on own overtemp drive");

  // own drive without enable and no outside pull stays quiet
  silent_mode_a: assert property ((ot_oe_q && !fullspeed_en_q) |=> !full_q)
    else $error("full speed forced in silent mode");

  // external pull while we release the pin forces full speed
  ext_pull_full_a: assert property ((!overtemp_pin_i && !ot_oe_q) |=> full_q)
    else $error("external overtemp pull ignored");

  // revision field reads back unchanged
  rev_field_a: assert property ((reg_rd && reg_addr == fan_cfg_pkg::ADDR_CFG3) |=>
      (rdata_q[3:0] == REVISION))
    else $error("revision field changed");

  // reserved config four bits read back their fixed pattern
  cfg4_reserved_a: assert property ((reg_rd && reg_addr == fan_cfg_pkg::ADDR_CFG4) |=>
      (rdata_q[3:0] == fan_cfg_pkg::CFG4_FIXED[3:0]))
    else $error("config four reserved bits moved");

  // pulses per revolution follows its select
  ppr_follow_a: assert property (##1 (ppr_q == (($past(ppr_sel_q)) ?
      fan_cfg_pkg::PPR_FOUR : fan_cfg_pkg::PPR_TWO)))
    else $error("pulses per revolution mismatch");

  // overlimit pin released whenever its enable is clear
  overlimit_off_a: assert property (!ol_en_q |=> !ol_oe_q)
    else $error("overlimit pin driven while disabled");

  // read of a flag whose condition is gone and no new event clears it
  read_clear_a: assert property ((reg_rd && reg_addr == fan_cfg_pkg::ADDR_STATUS &&
      !monitor_tick && !soft_rst && !limit_cond[0]) |=> !status_q[0])
    else $error("status flag survived read");

  // flag with live condition survives a read
  sticky_hold_a: assert property ((status_q[2] && limit_cond[2] && !soft_rst) |=>
      status_q[2])
    else $error("sticky flag lost while condition holds");

  // monitor tick with a condition sets the flag even during a read
  set_wins_a: assert property ((monitor_tick && limit_cond[2] && !soft_rst) |=>
      status_q[2])
    else $error("event lost during read");

  // failure flag survives reads until software reset
  fail_hold_a: assert property ((status_q[5] && !soft_rst) |=> status_q[5])
    else $error("failure flag cleared without reset");

  // critical condition drives overtemp from the next cycle
  crit_drive_a: assert property (remote_crit_cond |=> ot_oe_q)
    else $error("overtemp not driven on critical");

  // read data is the status image of the strobe cycle
  read_capture_a: assert property ((reg_rd && reg_addr == fan_cfg_pkg::ADDR_STATUS) |=>
      (rvalid_q && rdata_q == $past(status_q)))
    else $error("read data not the pre-clear image");

  // main scenarios
  cover_ext_pull_c: cover property (ext_pull ##1 full_q);
  cover_read_clear_c: cover property (status_q[0] ##1 (reg_rd &&
      reg_addr == fan_cfg_pkg::ADDR_STATUS) ##1 !status_q[0]);
  cover_fail_c: cover property (status_q[5] && reg_rd);
  cover_overlimit_c: cover property (ol_oe_q);

endmodule : fan_monitor_config_status_regs

`default_nettype wire

// [test/reg_host_model.sv]
// Purpose: host side of the register port, issuing byte reads and writes
// Assumes: requests change just after a falling edge and are taken at the next rising edge
// Notes: address and data show the inverse of the last value while no request is made
`default_nettype none

module reg_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // one byte write, strobe held across one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  // one byte read, answer awaited under a bound
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int i;
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = 1'b0;
    d = 8'h00;
    for (i = 0; i < 4; i++) begin
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
        break;
      end
      @(negedge clk);
    end
  endtask : rd

endmodule : reg_host_model

`default_nettype wire

// [test/testbench.sv]
// Purpose: self-checking bench for the fan monitor configuration and status bank
// Assumes: shortened refresh counts of 8 and 20 cycles
// Notes: inputs change at the falling edge; outputs are sampled there too
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [3:0] REV = 4'h5; // arbitrary value
  int miscompares = 0;
  int num_checks = 0;
  int n;
  int i;
  logic clk, rst, soft_rst, monitor_tick, ext_pull_n;
  logic remote_crit_cond, remote_fail_cond, overlimit_cond;
  logic [7:0] limit_cond, reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, overtemp_pin, overtemp_pin_o, overtemp_pin_oe;
  logic overlimit_pin_o, overlimit_pin_oe, fan_full_speed, fast_speed_update;
  logic speed_update_tick, mode_configured;
  logic [2:0] pulses_per_rev;

  // open-drain overtemp wire from our drive and an outside pull
  assign overtemp_pin = ext_pull_n & (overtemp_pin_oe ? overtemp_pin_o : 1'b1);

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  reg_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  fan_monitor_config_status_regs #(.FAST_CYCLES(8), .SLOW_CYCLES(20), .REVISION(REV)) dut (
    .clk(clk), .rst(rst), .soft_rst(soft_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .monitor_tick(monitor_tick), .limit_cond(limit_cond),
    .remote_crit_cond(remote_crit_cond), .remote_fail_cond(remote_fail_cond),
    .overlimit_cond(overlimit_cond), .overtemp_pin_i(overtemp_pin),
    .overtemp_pin_o(overtemp_pin_o), .overtemp_pin_oe(overtemp_pin_oe),
    .overlimit_pin_o(overlimit_pin_o), .overlimit_pin_oe(overlimit_pin_oe),
    .fan_full_speed(fan_full_speed), .pulses_per_rev(pulses_per_rev),
    .fast_speed_update(fast_speed_update), .speed_update_tick(speed_update_tick),
    .mode_configured(mode_configured));

  // closing report
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // read one register and compare
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    bit ok;
    host.rd(a, d, ok);
    if (!ok) begin
      miscompares++;
      $display("Error %s read answer missing", what);
      give_verdict();
    end else begin
      `CHK(what, exp, d)
    end
  endtask : rdchk

  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask : step

  task automatic pulse_tick;
    @(negedge clk);
    monitor_tick = 1'b1;
    @(negedge clk);
    monitor_tick = 1'b0;
  endtask : pulse_tick

  // cycles between two refresh ticks, bounded
  task automatic tick_gap(output int k);
    int j;
    for (j = 0; j < 100 && speed_update_tick !== 1'b1; j++) @(negedge clk);
    @(negedge clk);
    for (k = 1; k < 100 && speed_update_tick !== 1'b1; k++) @(negedge clk);
    // a tick that never comes ends the run
    if (j == 100 || k == 100) begin
      miscompares++;
      $display("Error refresh tick missing expected tick seen none");
      give_verdict();
    end
  endtask : tick_gap

  // main sequence
  initial begin
    rst = 1'b1;
    soft_rst = 1'b0;
    monitor_tick = 1'b0;
    ext_pull_n = 1'b1;
    limit_cond = 8'h00;
    remote_crit_cond = 1'b0;
    remote_fail_cond = 1'b0;
    overlimit_cond = 1'b0;
    step(16);
    rst = 1'b0;
    // reset values and read-only fields
    rdchk(fan_cfg_pkg::ADDR_CFG4, 8'h08, "cfg4 reset");
    rdchk(fan_cfg_pkg::ADDR_CFG3, {4'h8, REV}, "cfg3 reset");
    rdchk(fan_cfg_pkg::ADDR_STATUS, 8'h00, "status reset");
    `CHK("ppr reset", 3'h2, pulses_per_rev)
    `CHK("mode reset", 1'b0, mode_configured)
    tick_gap(n);
    `CHK("slow gap", 20, n)
    // writable bits, reserved bits and unmapped place
    host.wr(fan_cfg_pkg::ADDR_CFG4, 8'hf7);
    rdchk(fan_cfg_pkg::ADDR_CFG4, 8'hf8, "cfg4 write");
    `CHK("mode set", 1'b1, mode_configured)
    `CHK("ppr four", 3'h4, pulses_per_rev)
    `CHK("fast set", 1'b1, fast_speed_update)
    tick_gap(n);
    `CHK("fast gap", 8, n)
    host.wr(fan_cfg_pkg::ADDR_CFG3, 8'h7a);
    rdchk(fan_cfg_pkg::ADDR_CFG3, {4'h0, REV}, "cfg3 write");
    rdchk(8'h10, 8'h00, "unmapped");
    // own drive versus outside pull, enable clear then set
    for (i = 0; i < 2; i++) begin
      host.wr(fan_cfg_pkg::ADDR_CFG3, {i[0], 7'h00});
      remote_crit_cond = 1'b1;
      step(3);
      `CHK("overtemp drive", 1'b1, overtemp_pin_oe)
      `CHK("full own drive", i[0], fan_full_speed)
      remote_crit_cond = 1'b0;
      ext_pull_n = 1'b0;
      step(3);
      `CHK("full outside pull", 1'b1, fan_full_speed)
      ext_pull_n = 1'b1;
      step(3);
      `CHK("full released", 1'b0, fan_full_speed)
    end
    // sticky flags and read clear
    limit_cond = 8'h04;
    pulse_tick();
    rdchk(fan_cfg_pkg::ADDR_STATUS, 8'h04, "flag set");
    rdchk(fan_cfg_pkg::ADDR_STATUS, 8'h04, "flag held");
    limit_cond = 8'h00;
    rdchk(fan_cfg_pkg::ADDR_STATUS, 8'h04, "flag last");
    rdchk(fan_cfg_pkg::ADDR_STATUS, 8'h00, "flag cleared");
    limit_cond = 8'h04;
    pulse_tick();
    limit_cond = 8'h00;
    rdchk(fan_cfg_pkg::ADDR_STATUS, 8'h04, "flag reasserted");
    remote_crit_cond = 1'b1;
    pulse_tick();
    remote_crit_cond = 1'b0;
    rdchk(fan_cfg_pkg::ADDR_STATUS, 8'h10, "critical flag");
    // event at the read edge survives the read
    limit_cond = 8'h01;
    fork
      rdchk(fan_cfg_pkg::ADDR_STATUS, 8'h00, "read at event");
      pulse_tick();
    join
    limit_cond = 8'h00;
    rdchk(fan_cfg_pkg::ADDR_STATUS, 8'h01, "event kept");
    // failure flag ignores reads, drives overlimit pin
    remote_fail_cond = 1'b1;
    step(1);
    remote_fail_cond = 1'b0;
    step(3);
    `CHK("overlimit by failure", 1'b1, overlimit_pin_oe)
    rdchk(fan_cfg_pkg::ADDR_STATUS, 8'h20, "failure flag");
    rdchk(fan_cfg_pkg::ADDR_STATUS, 8'h20, "failure held");
    soft_rst = 1'b1;
    step(1);
    soft_rst = 1'b0;
    rdchk(fan_cfg_pkg::ADDR_STATUS, 8'h00, "soft reset");
    // overlimit pin enable
    host.wr(fan_cfg_pkg::ADDR_CFG4, 8'h80);
    overlimit_cond = 1'b1;
    step(3);
    `CHK("overlimit released", 1'b0, overlimit_pin_oe)
    `CHK("ppr two", 3'h2, pulses_per_rev)
    host.wr(fan_cfg_pkg::ADDR_CFG4, 8'h90);
    step(3);
    `CHK("overlimit driven", 1'b1, overlimit_pin_oe)
    `CHK("overlimit low", 1'b0, overlimit_pin_o)
    `CHK("overtemp low", 1'b0, overtemp_pin_o)
    // second reset in mid-run brings back the power-on values
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    `CHK("overlimit after reset", 1'b0, overlimit_pin_oe)
    rdchk(fan_cfg_pkg::ADDR_CFG3, {4'h8, REV}, "cfg3 rereset");
    rdchk(fan_cfg_pkg::ADDR_CFG4, 8'h08, "cfg4 rereset");
    give_verdict();
  end

endmodule : testbench

`undef CHK

`default_nettype wire
